// file: bench/tb_msr_status_regs.sv
// Self-checking bench for the monitor status register bank
`timescale 1ns/1ps
module tb_msr_status_regs;
   import msr_pkg::*;

   logic                 clk_in = 1'b0;
   logic                 rstn_in = 1'b0;
   logic [31:0]          haddr = '0;
   logic [1:0]           htrans = 2'b00;
   logic                 hwrite = 1'b0;
   logic [31:0]          hwdata = '0;
   logic [31:0]          hrdata;
   logic                 hready;
   logic                 hresp;
   logic                 cmp_start;
   logic                 bal_act;
   logic [NUM_CELLS-1:0] bal_sel;
   logic [1:0]           act_q[$];
   int                   cmp_starts = 0;
   msr_cmp_s             cmp = '0;
   msr_engine_s          eng = '0;
   msr_ntc_t             ntc;
   logic [NUM_PINS-1:0]  gpio = '0;
   logic [NUM_PINS-1:0]  dmode = '1;
   logic [7:0]           devst = 8'h00;
   logic                 rd_pend = 1'b0;
   logic [31:0]          exp_q[$];
   string                name_q[$];
   int                   seed = 23;
   int                   miscompares = 0;
   int                   compares = 0;
   int                   cycles = 0;
   logic [15:0]          sel_t[5] = '{16'h16db, 16'h06db, 16'h0007, 16'h5555, 16'h06db};
   logic [4:0]           noadj_t = 5'b01010;
   logic [4:0]           inv_t = 5'b00111;

   always #5 clk_in = ~clk_in;

   msr_status_regs dut_u (
      .clk_in               (clk_in),
      .rstn_in              (rstn_in),
      .hsel_in              (1'b1),
      .haddr_in             (haddr),
      .htrans_in            (htrans),
      .hwrite_in            (hwrite),
      .hsize_in             (3'b010),
      .hwdata_in            (hwdata),
      .hready_in            (hready),
      .hrdata_out           (hrdata),
      .hreadyout_out        (hready),
      .hresp_out            (hresp),
      .cmp_done_in          (cmp),
      .cmp_start_out        (cmp_start),
      .gpio_pin_in          (gpio),
      .gpio_digital_mode_in (dmode),
      .engine_in            (eng),
      .ntc_temp_in          (ntc),
      .device_status_in     (devst),
      .bal_cell_sel_out     (bal_sel),
      .bal_active_out       (bal_act)
   );

   function automatic logic [31:0] ba(input logic [IDX_W-1:0] i);
      return {18'h0, i, 2'b00};
   endfunction : ba

   function automatic logic [31:0] st(input logic inv, otp, pau, run, abt, cpl);
      return (32'(inv) << BAL_INVALID_BIT) | (32'(otp) << BAL_OTPAUSE_BIT)
           | (32'(pau) << BAL_PAUSED_BIT) | (32'(run) << BAL_RUNNING_BIT)
           | (32'(abt) << BAL_ABORT_BIT) | (32'(cpl) << BAL_COMPLETE_BIT);
   endfunction : st

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One single transfer; reads leave their expectation for the monitor
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e, input string n);
      @(posedge clk_in);
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk_in); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      if (!w) begin
         exp_q.push_back(e);
         name_q.push_back(n);
         act_q.push_back({a == ba(IDX_BAL_STATUS), e[BAL_RUNNING_BIT] & ~e[BAL_PAUSED_BIT]});
         rd_pend <= 1'b1;
      end
      do @(posedge clk_in); while (hready !== 1'b1);
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 32'h0, "");
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
      bus(a, 1'b0, 32'h0, e, n);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask : idle

   // Monitor: read data taken at the edge that ends the data phase
   always @(posedge clk_in) begin
      if (rd_pend === 1'b1 && hready === 1'b1) begin
         rd_pend <= 1'b0;
         chk(name_q.pop_front(), exp_q.pop_front(), hrdata);
         chk("hresp", 32'h0, 32'(hresp));
         if (act_q[0][1]) begin
            chk("bal_active", 32'(act_q[0][0]), 32'(bal_act));
         end
         act_q.delete(0);
      end
   end

   // Start pulses towards the comparison engine
   always @(posedge clk_in) begin
      if (cmp_start === 1'b1) begin
         cmp_starts++;
      end
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      for (int i = 0; i < NUM_NTC; i++) begin
         ntc[i] <= 4'($random(seed)) & 4'h7;
      end
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(ba(IDX_CMP_STATUS), 32'h0, "cmp_status reset");
      rd(ba(IDX_PIN_LEVEL), 32'h0, "pin_level reset");
      rd(ba(IDX_BAL_STATUS), 32'h0, "bal_status reset");
      rd(32'h0000_0ff0, 32'h0, "unmapped");
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_in);
         cmp  <= msr_cmp_s'(3'(1 << k));
         gpio <= 8'($random(seed));
         dmode <= 8'($random(seed));
         devst <= 8'($random(seed));
         @(posedge clk_in);
         cmp <= '0;
         idle(2);
         rd(ba(IDX_CMP_STATUS), 32'(1 << k), "cmp ready");
         rd(ba(IDX_PIN_LEVEL), 32'(gpio & dmode), "pin_level");
         rd(ba(IDX_DEV_STATUS), 32'(devst), "dev_status");
         wr(ba(IDX_BAL_CTRL), 32'(1) << CTRL_CMP_START_BIT);
         idle(2);
         rd(ba(IDX_CMP_STATUS), 32'h0, "cmp cleared");
      end
      for (int i = 0; i < 5; i++) begin
         wr(ba(IDX_CELL_SEL), 32'(sel_t[i]));
         wr(ba(IDX_BAL_CTRL), (32'(1) << CTRL_BAL_START_BIT)
                             | (32'(noadj_t[i]) << CTRL_NOADJ_BIT));
         idle(2);
         rd(ba(IDX_BAL_STATUS), st(inv_t[i], 0, 0, !inv_t[i], 0, 0), "bal cfg");
      end
      wr(ba(IDX_BAL_CTRL), (32'(1) << CTRL_OTEN_BIT) | (32'h8 << CTRL_THR_LSB));
      @(posedge clk_in);
      ntc[3] <= 4'h9;
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 1, 1, 1, 0, 0), "overtemp");
      @(posedge clk_in);
      ntc[3] <= 4'h8;
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 0, 1, 0, 0), "at threshold");
      wr(ba(IDX_BAL_CTRL), 32'(1) << CTRL_PAUSE_BIT);
      @(posedge clk_in);
      eng.unmasked_fault <= 1'b1;
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 1, 1, 0, 0), "paused fault");
      wr(ba(IDX_BAL_CTRL), 32'h0);
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 0, 0, 1, 0), "abort");
      @(posedge clk_in);
      eng.unmasked_fault <= 1'b0;
      wr(ba(IDX_BAL_CTRL), 32'(1) << CTRL_BAL_START_BIT);
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 0, 1, 0, 0), "abort cleared");
      @(posedge clk_in);
      eng.balance_die_temp_warning <= 1'b1;
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 1, 1, 1, 0, 0), "die warning");
      @(posedge clk_in);
      eng.balance_die_temp_warning <= 1'b0;
      eng.all_cells_done <= 1'b1;
      idle(3);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 0, 0, 0, 1), "complete");
      @(posedge clk_in);
      eng.all_cells_done <= 1'b0;
      wr(ba(IDX_BAL_CTRL), 32'(1) << CTRL_BAL_START_BIT);
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 0, 1, 0, 0), "complete cleared");
      wr(ba(IDX_BAL_STATUS), 32'hffff_ffff);
      wr(ba(IDX_PIN_LEVEL), 32'hffff_ffff);
      idle(2);
      rd(ba(IDX_BAL_STATUS), st(0, 0, 0, 1, 0, 0), "status write");
      rd(ba(IDX_PIN_LEVEL), 32'(gpio & dmode), "pin write");
      idle(2);
      chk("cell_sel_out", 32'(sel_t[4]), 32'(bal_sel));
      chk("cmp_start pulses", 32'd3, 32'(cmp_starts));
      end_of_test();
   end
endmodule : tb_msr_status_regs

// file: rtl/msr_bal_check.sv
// Balancing selection checker: cell count and adjacency limits
`timescale 1ns/1ps
module msr_bal_check
   import msr_pkg::*;
(
   // Selection
   input  wire logic [msr_pkg::NUM_CELLS-1:0] cell_sel_in,
   input  wire logic                          forbid_adj_in,
   // Verdict
   output logic                               invalid_out
);
   logic [NUM_CELLS-2:0] pair;
   logic [NUM_CELLS-3:0] triple;
   logic [4:0]           count;

   genvar i;
   generate
      for (i = 0; i < NUM_CELLS - 1; i++) begin : g_pair
         assign pair[i] = cell_sel_in[i] & cell_sel_in[i+1];
         if (i < NUM_CELLS - 2) begin : g_triple
            assign triple[i] = pair[i] & cell_sel_in[i+2];
         end
      end
   endgenerate

   assign count = 5'($countones(cell_sel_in));

   always_comb begin
      invalid_out = 1'b0;
      if (count > 5'(MAX_BAL_CELLS)) begin
         invalid_out = 1'b1;
      end
      if (!forbid_adj_in && (|triple)) begin
         invalid_out = 1'b1;
      end
      if (forbid_adj_in && (|pair)) begin
         invalid_out = 1'b1;
      end
   end
endmodule : msr_bal_check

// file: rtl/msr_pin_sync.sv
// Two-stage synchroniser for the general-purpose pin levels
`timescale 1ns/1ps
module msr_pin_sync
   import msr_pkg::*;
(
   // Clock and reset
   input  wire logic                         clk_in,
   input  wire logic                         rstn_in,
   // Pins
   input  wire logic [msr_pkg::NUM_PINS-1:0] pins_in,
   output logic      [msr_pkg::NUM_PINS-1:0] pins_out
);
   msr_sync_s st_q;
   msr_sync_s st_d;

   always_comb begin
      st_d        = st_q;
      st_d.stage1 = pins_in;
      st_d.stage2 = st_q.stage1;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pins_out = st_q.stage2;
endmodule : msr_pin_sync

// file: rtl/msr_pkg.sv
// Constants, field layouts and carrier types for the monitor status register bank
package msr_pkg;
   localparam int NUM_PINS  = 8;
   localparam int NUM_CELLS = 16;
   localparam int NUM_NTC   = 8;
   localparam int THR_W     = 4;
   localparam int IDX_W     = 12;
   localparam int ADDR_W    = IDX_W + 2;

   // Most cells allowed in one balancing selection
   localparam int MAX_BAL_CELLS = 8;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CMP_STATUS = 12'h528;
   localparam logic [IDX_W-1:0] IDX_PIN_LEVEL  = 12'h52a;
   localparam logic [IDX_W-1:0] IDX_BAL_STATUS = 12'h52b;
   localparam logic [IDX_W-1:0] IDX_DEV_STATUS = 12'h52c;
   localparam logic [IDX_W-1:0] IDX_BAL_CTRL   = 12'h600;
   localparam logic [IDX_W-1:0] IDX_CELL_SEL   = 12'h601;

   // Comparison status fields
   localparam int CMP_OPENWIRE_BIT = 2;
   localparam int CMP_SWITCH_BIT   = 1;
   localparam int CMP_CELLAUX_BIT  = 0;

   // Balancing status fields
   localparam int BAL_INVALID_BIT  = 7;
   localparam int BAL_OTPAUSE_BIT  = 6;
   localparam int BAL_PAUSED_BIT   = 5;
   localparam int BAL_RUNNING_BIT  = 3;
   localparam int BAL_ABORT_BIT    = 2;
   localparam int BAL_COMPLETE_BIT = 0;

   // Balance control fields
   localparam int CTRL_BAL_START_BIT = 0;
   localparam int CTRL_CMP_START_BIT = 1;
   localparam int CTRL_PAUSE_BIT     = 2;
   localparam int CTRL_NOADJ_BIT     = 3;
   localparam int CTRL_OTEN_BIT      = 4;
   localparam int CTRL_THR_LSB       = 8;

   // AHB transfer type
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HTRANS_SEQ    = 2'b11;

   typedef logic [NUM_NTC-1:0][THR_W-1:0] msr_ntc_t;

   typedef struct packed {
      logic [THR_W-1:0] overtemp_balance_threshold;
      logic             overtemp_balance_ctrl_enable;
      logic             forbid_adjacent_balancing;
      logic             balance_pause_request;
   } msr_ctrl_s;

   typedef struct packed {
      logic bal_openwire_cmp_ready;
      logic bal_switch_cmp_ready;
      logic cell_vs_aux_cmp_ready;
   } msr_cmp_s;

   typedef struct packed {
      logic bal_config_invalid;
      logic overtemp_pause_detect;
      logic balancing_paused;
      logic balancing_running;
      logic balance_fault_abort;
      logic balancing_complete;
   } msr_bal_s;

   typedef struct packed {
      logic all_cells_done;
      logic unmasked_fault;
      logic balance_die_temp_warning;
   } msr_engine_s;

   typedef struct packed {
      msr_ctrl_s              ctrl;
      logic [NUM_CELLS-1:0]   cell_sel;
      msr_cmp_s               cmp;
      msr_bal_s               bal;
      logic [NUM_PINS-1:0]    pins;
      logic                   wr_pend;
      logic [IDX_W-1:0]       wr_idx;
      logic [31:0]            rdata;
      logic                   ready;
      logic                   balance_start;
      logic                   cmp_go;
      logic                   bal_active;
   } msr_state_s;

   localparam msr_state_s MSR_STATE_RST = '{ready: 1'b1, default: '0};

   typedef struct packed {
      logic [NUM_PINS-1:0] stage2;
      logic [NUM_PINS-1:0] stage1;
   } msr_sync_s;
endpackage : msr_pkg

// file: rtl/msr_status_regs.sv
// AHB-Lite status register bank for comparison, pin and cell-balancing state
//
// Contract
// - Open-wire comparison ready sets when that comparison ends; a comparison start clears it.
// - Switch comparison ready sets when that comparison ends; a comparison start clears it.
// - Cell-versus-aux ready sets on completion, clears on comparison start, 0 is not ready.
// - Each pin bit shows its pin level, 1 high, 0 low, while that pin is in digital mode.
// - A balance start with more than eight cells selected is refused and flagged invalid.
// - With adjacency forbidding off, more than two adjacent selected cells is invalid.
// - With adjacency forbidding on, any two adjacent selected cells is invalid.
// - The invalid flag is re-evaluated at every balance start, 1 invalid and 0 valid.
// - Overtemp pause detect sets on thermistor over threshold when enabled, or die warning.
// - Paused reads 1 while balancing is paused by overtemp or by the pause request.
// - Running reads 1 from start until done or abort, including while paused.
// - An unmasked fault aborts balancing and sets abort; a balance start clears it.
// - No abort happens while paused; abort on fault returns when the pause ends.
// - Complete sets when all balancing ends; a balance start clears it.
`timescale 1ns/1ps
module msr_status_regs
   import msr_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          rstn_in,
   // AHB-Lite slave
   input  wire logic                          hsel_in,
   input  wire logic [31:0]                   haddr_in,
   input  wire logic [1:0]                    htrans_in,
   input  wire logic                          hwrite_in,
   input  wire logic [2:0]                    hsize_in,
   input  wire logic [31:0]                   hwdata_in,
   input  wire logic                          hready_in,
   output logic      [31:0]                   hrdata_out,
   output logic                               hreadyout_out,
   output logic                               hresp_out,
   // Comparison engine
   input  wire msr_pkg::msr_cmp_s             cmp_done_in,
   output logic                               cmp_start_out,
   // General-purpose pins
   input  wire logic [msr_pkg::NUM_PINS-1:0]  gpio_pin_in,
   input  wire logic [msr_pkg::NUM_PINS-1:0]  gpio_digital_mode_in,
   // Balancing engine
   input  wire msr_pkg::msr_engine_s          engine_in,
   input  wire msr_pkg::msr_ntc_t             ntc_temp_in,
   input  wire logic [7:0]                    device_status_in,
   output logic      [msr_pkg::NUM_CELLS-1:0] bal_cell_sel_out,
   output logic                               bal_active_out
);
   msr_state_s          st_q;
   msr_state_s          st_d;
   logic [NUM_PINS-1:0] pins_sync;
   logic                cfg_invalid;
   logic                ntc_hot;
   logic                ot_cond;
   logic                addr_ok;
   logic                take;
   logic [IDX_W-1:0]    idx;
   logic [31:0]         rd_mux;

   msr_pin_sync u_pin_sync (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .pins_in  (gpio_pin_in),
      .pins_out (pins_sync)
   );

   msr_bal_check u_bal_check (
      .cell_sel_in   (st_q.cell_sel),
      .forbid_adj_in (st_q.ctrl.forbid_adjacent_balancing),
      .invalid_out   (cfg_invalid)
   );

   // Any thermistor above threshold
   always_comb begin
      ntc_hot = 1'b0;
      for (int n = 0; n < NUM_NTC; n++) begin
         if (ntc_temp_in[n] > st_q.ctrl.overtemp_balance_threshold) begin
            ntc_hot = 1'b1;
         end
      end
   end

   assign ot_cond = (st_q.ctrl.overtemp_balance_ctrl_enable & ntc_hot)
                    | engine_in.balance_die_temp_warning;

   // Address phase decode
   assign idx     = haddr_in[ADDR_W-1:2];
   assign addr_ok = (haddr_in[31:ADDR_W] == '0) && (haddr_in[1:0] == 2'b00);
   assign take    = hsel_in && hready_in && htrans_in[1];

   // Read data; unused and reserved bits stay zero
   always_comb begin
      rd_mux = '0;
      if (addr_ok) begin
         unique case (idx)
            IDX_CMP_STATUS: begin
               rd_mux[CMP_OPENWIRE_BIT] = st_q.cmp.bal_openwire_cmp_ready;
               rd_mux[CMP_SWITCH_BIT]   = st_q.cmp.bal_switch_cmp_ready;
               rd_mux[CMP_CELLAUX_BIT]  = st_q.cmp.cell_vs_aux_cmp_ready;
            end
            IDX_PIN_LEVEL: begin
               rd_mux[NUM_PINS-1:0] = st_q.pins;
            end
            IDX_BAL_STATUS: begin
               rd_mux[BAL_INVALID_BIT]  = st_q.bal.bal_config_invalid;
               rd_mux[BAL_OTPAUSE_BIT]  = st_q.bal.overtemp_pause_detect;
               rd_mux[BAL_PAUSED_BIT]   = st_q.bal.balancing_paused;
               rd_mux[BAL_RUNNING_BIT]  = st_q.bal.balancing_running;
               rd_mux[BAL_ABORT_BIT]    = st_q.bal.balance_fault_abort;
               rd_mux[BAL_COMPLETE_BIT] = st_q.bal.balancing_complete;
            end
            IDX_DEV_STATUS: begin
               rd_mux[7:0] = device_status_in;
            end
            IDX_BAL_CTRL: begin
               rd_mux[CTRL_PAUSE_BIT] = st_q.ctrl.balance_pause_request;
               rd_mux[CTRL_NOADJ_BIT] = st_q.ctrl.forbid_adjacent_balancing;
               rd_mux[CTRL_OTEN_BIT]  = st_q.ctrl.overtemp_balance_ctrl_enable;
               rd_mux[CTRL_THR_LSB +: THR_W] = st_q.ctrl.overtemp_balance_threshold;
            end
            IDX_CELL_SEL: begin
               rd_mux[NUM_CELLS-1:0] = st_q.cell_sel;
            end
            default: begin
               rd_mux = '0;
            end
         endcase
      end
   end

   always_comb begin
      st_d        = st_q;
      st_d.ready  = 1'b1;
      st_d.balance_start = 1'b0;
      st_d.cmp_go = 1'b0;
      st_d.pins   = pins_sync & gpio_digital_mode_in;

      // Data phase of a write; status registers ignore writes
      if (st_q.wr_pend) begin
         st_d.wr_pend = 1'b0;
         if (st_q.wr_idx == IDX_BAL_CTRL) begin
            st_d.balance_start = hwdata_in[CTRL_BAL_START_BIT];
            st_d.cmp_go = hwdata_in[CTRL_CMP_START_BIT];
            st_d.ctrl.balance_pause_request        = hwdata_in[CTRL_PAUSE_BIT];
            st_d.ctrl.forbid_adjacent_balancing    = hwdata_in[CTRL_NOADJ_BIT];
            st_d.ctrl.overtemp_balance_ctrl_enable = hwdata_in[CTRL_OTEN_BIT];
            st_d.ctrl.overtemp_balance_threshold   = hwdata_in[CTRL_THR_LSB +: THR_W];
         end else if (st_q.wr_idx == IDX_CELL_SEL) begin
            st_d.cell_sel = hwdata_in[NUM_CELLS-1:0];
         end
      end

      // Address phase
      if (take) begin
         if (hwrite_in) begin
            st_d.wr_pend = addr_ok;
            st_d.wr_idx  = idx;
         end else begin
            st_d.rdata = rd_mux;
         end
      end

      // Comparison flags; a completion wins over a same-cycle start
      if (st_q.cmp_go) begin
         st_d.cmp = '0;
      end
      if (cmp_done_in.bal_openwire_cmp_ready) begin
         st_d.cmp.bal_openwire_cmp_ready = 1'b1;
      end
      if (cmp_done_in.bal_switch_cmp_ready) begin
         st_d.cmp.bal_switch_cmp_ready = 1'b1;
      end
      if (cmp_done_in.cell_vs_aux_cmp_ready) begin
         st_d.cmp.cell_vs_aux_cmp_ready = 1'b1;
      end

      // Balancing state
      if (st_q.balance_start) begin
         st_d.bal.bal_config_invalid    = cfg_invalid;
         st_d.bal.balance_fault_abort   = 1'b0;
         st_d.bal.balancing_complete    = 1'b0;
         st_d.bal.overtemp_pause_detect = 1'b0;
         st_d.bal.balancing_paused      = 1'b0;
         st_d.bal.balancing_running     = !cfg_invalid;
      end else if (st_q.bal.balancing_running) begin
         st_d.bal.overtemp_pause_detect = ot_cond;
         st_d.bal.balancing_paused      = ot_cond | st_q.ctrl.balance_pause_request;
         if (engine_in.unmasked_fault && !st_q.bal.balancing_paused) begin
            st_d.bal.balance_fault_abort = 1'b1;
            st_d.bal.balancing_running   = 1'b0;
            st_d.bal.balancing_paused    = 1'b0;
         end else if (engine_in.all_cells_done && !st_q.bal.balancing_paused) begin
            st_d.bal.balancing_complete = 1'b1;
            st_d.bal.balancing_running  = 1'b0;
            st_d.bal.balancing_paused   = 1'b0;
         end
      end else begin
         st_d.bal.balancing_paused = 1'b0;
      end
      st_d.bal_active = st_d.bal.balancing_running & !st_d.bal.balancing_paused;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= MSR_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign hrdata_out       = st_q.rdata;
   assign hreadyout_out    = st_q.ready;
   assign hresp_out        = st_q.wr_pend & 1'b0;
   assign cmp_start_out    = st_q.cmp_go;
   assign bal_cell_sel_out = st_q.cell_sel;
   assign bal_active_out   = st_q.bal_active;

   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_openwire_clear;
      st_q.cmp_go && !cmp_done_in.bal_openwire_cmp_ready
         |=> !st_q.cmp.bal_openwire_cmp_ready;
   endproperty
   a_openwire_clear: assert property (p_openwire_clear)
      else $error("open-wire ready not cleared by comparison start");

   property p_switch_set;
      cmp_done_in.bal_switch_cmp_ready |=> st_q.cmp.bal_switch_cmp_ready;
   endproperty
   a_switch_set: assert property (p_switch_set)
      else $error("switch ready not set on completion");

   property p_cellaux_hold;
      !st_q.cmp_go && st_q.cmp.cell_vs_aux_cmp_ready |=> st_q.cmp.cell_vs_aux_cmp_ready;
   endproperty
   a_cellaux_hold: assert property (p_cellaux_hold)
      else $error("cell-vs-aux ready lost without start");

   property p_pin_mask;
      ##1 (st_q.pins & ~$past(gpio_digital_mode_in)) == '0;
   endproperty
   a_pin_mask: assert property (p_pin_mask)
      else $error("pin bit shown while not in digital mode");

   property p_too_many;
      st_q.balance_start && ($countones(st_q.cell_sel) > MAX_BAL_CELLS)
         |=> st_q.bal.bal_config_invalid && !st_q.bal.balancing_running;
   endproperty
   a_too_many: assert property (p_too_many)
      else $error("too many cells accepted");

   property p_adj_pair;
      st_q.balance_start && st_q.ctrl.forbid_adjacent_balancing
         && ((st_q.cell_sel & (st_q.cell_sel >> 1)) != '0)
         |=> st_q.bal.bal_config_invalid;
   endproperty
   a_adj_pair: assert property (p_adj_pair)
      else $error("adjacent pair accepted while forbidden");

   property p_valid_start;
      st_q.balance_start && !cfg_invalid
         |=> !st_q.bal.bal_config_invalid && st_q.bal.balancing_running
             && !st_q.bal.balance_fault_abort && !st_q.bal.balancing_complete;
   endproperty
   a_valid_start: assert property (p_valid_start)
      else $error("valid start not taken");

   property p_paused_running;
      st_q.bal.balancing_paused |-> st_q.bal.balancing_running;
   endproperty
   a_paused_running: assert property (p_paused_running)
      else $error("paused without running");

   property p_pause_req;
      st_q.bal.balancing_running && !st_q.balance_start && st_q.ctrl.balance_pause_request
         && !engine_in.unmasked_fault && !engine_in.all_cells_done
         |=> st_q.bal.balancing_paused;
   endproperty
   a_pause_req: assert property (p_pause_req)
      else $error("pause request not shown");

   property p_overtemp;
      st_q.bal.balancing_running && !st_q.balance_start && engine_in.balance_die_temp_warning
         |=> st_q.bal.overtemp_pause_detect && !bal_active_out;
   endproperty
   a_overtemp: assert property (p_overtemp)
      else $error("die warning not detected");

   property p_abort;
      st_q.bal.balancing_running && !st_q.balance_start && !st_q.bal.balancing_paused
         && engine_in.unmasked_fault
         |=> st_q.bal.balance_fault_abort && !st_q.bal.balancing_running && !bal_active_out;
   endproperty
   a_abort: assert property (p_abort)
      else $error("fault did not abort");

   property p_no_abort_paused;
      st_q.bal.balancing_paused && !st_q.balance_start |=> !st_q.bal.balance_fault_abort;
   endproperty
   a_no_abort_paused: assert property (p_no_abort_paused)
      else $error("abort while paused");

   property p_complete_clear;
      st_q.balance_start |=> !st_q.bal.balancing_complete;
   endproperty
   a_complete_clear: assert property (p_complete_clear)
      else $error("complete not cleared by start");

   property p_rsvd_zero;
      take && !hwrite_in && addr_ok && (idx == IDX_BAL_STATUS)
         |=> (st_q.rdata[31:8] == '0) && !st_q.rdata[4] && !st_q.rdata[1];
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved status bits not zero");

   c_valid_start: cover property (st_q.balance_start ##1 st_q.bal.balancing_running);
   c_abort: cover property ($rose(st_q.bal.balance_fault_abort));
   c_complete: cover property ($rose(st_q.bal.balancing_complete));
   c_cmp_ready: cover property (st_q.cmp_go ##[1:20] st_q.cmp.bal_openwire_cmp_ready);
endmodule : msr_status_regs
